// File: pkg/can_handler_pkg.sv
// Constants and types shared by the message object handler.
// Assumes a 32-bit AXI4-Lite bus and a separate protocol core.
package can_handler_pkg;
	// Object memory size
	localparam int NUM_OBJ = 32;
	// Recessive bits that mark bus idle
	localparam logic [3:0] IDLE_BITS = 4'hB;
	// Global register byte offsets
	localparam logic [11:0] CTL_OFS  = 12'h000;
	localparam logic [11:0] TXRQ_OFS = 12'h004;
	localparam logic [11:0] NWDA_OFS = 12'h008;
	// Interface sets at 0x020 and 0x040
	localparam logic [1:0] IF1_SEL = 2'h1;
	localparam logic [1:0] IF2_SEL = 2'h2;
	// Offsets within one interface set
	localparam logic [4:0] CMSK_OFS = 5'h00;
	localparam logic [4:0] CRQ_OFS  = 5'h04;
	localparam logic [4:0] MSK_OFS  = 5'h08;
	localparam logic [4:0] ARB_OFS  = 5'h0C;
	localparam logic [4:0] MCTL_OFS = 5'h10;
	localparam logic [4:0] DA_OFS   = 5'h14;
	localparam logic [4:0] DB_OFS   = 5'h18;
	// Command mask bits
	localparam int CM_WR = 7, CM_MASK = 6, CM_ARB = 5, CM_CTRL = 4;
	localparam int CM_CLRINT = 3, CM_NEW_DATA_FLAG = 2, CM_DATA_A = 1, CM_DATA_B = 0;
	// Message control bits, length code in 3:0
	localparam int MC_NEW_DATA_FLAG = 15, MC_MESSAGE_LOST_FLAG = 14, MC_INT_PENDING_FLAG = 13, MC_USE_ACCEPTANCE_MASK = 12;
	localparam int MC_TX_INT_ENABLE = 11, MC_RX_INT_ENABLE = 10, MC_REMOTE_REPLY_ENABLE = 9, MC_TRANSMIT_REQUEST = 8, MC_EOB = 7;
	// Upper bits of arbitration and mask words; busy and control register bits
	localparam int ARB_VALID = 31, ARB_XTD = 30, ARB_DIR = 29;
	localparam int MSK_MASK_EXTENDED_FLAG = 31, MSK_MASK_DIRECTION_FLAG = 30;
	localparam int CRQ_BUSY = 15, CTL_INIT = 0, CTL_BUSON = 1;
	// Values after reset
	localparam logic CTL_INIT_RST = 1'b1;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// One message object
	typedef struct packed {
		logic        valid, xtd, dir;
		logic [28:0] id, mask;
		logic        mask_extended_flag, mask_direction_flag, use_acceptance_mask, end_of_block, new_data_flag, message_lost_flag;
		logic        rx_int_enable, tx_int_enable, int_pending_flag, remote_reply_enable, transmit_request;
		logic [3:0]  dlc;
		logic [63:0] data;
	} msg_obj_t;
	// One interface register set
	typedef struct packed {
		logic [7:0] cmask;
		msg_obj_t   buffer;
		logic       busy;
		logic [4:0] idx;
	} iface_t;
endpackage

// File: src/can_message_object_handler.sv
// Message handler: object RAM, two interface sets, tx scheduling, rx filter.
// Assumes a protocol core that strobes received frames and loads tx frames.
//
// Functional notes
// [R1] Clearing init starts bus synchronisation, then traffic
// [R2] Store arbitration, length and eight data bytes
// [R3] Object stays consistent under concurrent accesses
// [R4] Software sets request and new data to send
// [R5] Pending requests sent one by one, priority order
// [R6] Update before start replaces the pending data
// [R7] Two independent interface sets reach the RAM
// [R8] Load best pending object when idle; clear new data
// [R9] Success clears request unless new data arrived
// [R10] Tx interrupt enable sets pending after success
// [R11] Failed frame retried; higher priority goes first
// [R12] Software sets up transmit objects correctly
// [R13] Standard identifier uses bits 28:18 only
// [R14] Remote frame with reply enable sets request
// [R15] Use-mask applies identifier, extended, direction masks
// [R16] Software keeps all eight data bytes valid
// [R17] Data-only update sets data and request together
// [R18] New data with request survives running transmission
// [R19] Scan objects from 1 upward, first match wins
// [R20] Store sets new data; overwrite sets lost flag
// [R21] Rx interrupt enable sets pending, clears request
// [R22] Remote without reply: ignore, or store if masked
// [R23] Lower object number means higher tx priority
// [R24] Thirty-two objects reached only through interfaces
// [R25] Wait eleven recessive bits after leaving init
// [R26] Simultaneous interface requests served in fixed order
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module can_message_object_handler
	import can_handler_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Sampled bus bits for idle detection
	input  wire logic        bit_strobe,
	input  wire logic        bus_bit,
	// Received frame from the core
	input  wire logic        rx_valid,
	input  wire logic [28:0] rx_id,
	input  wire logic        rx_xtd,
	input  wire logic        rx_rtr,
	input  wire logic [3:0]  rx_dlc,
	input  wire logic [63:0] rx_data,
	// Transmit shift register handshake
	input  wire logic        tx_ready,
	input  wire logic        tx_done,
	input  wire logic        tx_fail,
	output logic             tx_load,
	output logic [28:0]      tx_id,
	output logic             tx_xtd,
	output logic             tx_remote,
	output logic [3:0]       tx_dlc,
	output logic [63:0]      tx_data,
	// Status
	output logic             bus_active
);
	// All state of the block
	typedef struct packed {
		msg_obj_t [NUM_OBJ-1:0] objs; // R24
		iface_t [1:0] ifs;
		logic         init, bus_active;
		logic [3:0]   idle_cnt;
		logic         tx_active, tx_dirty, tx_load;
		logic [4:0]   tx_obj;
		logic [28:0]  tx_id;
		logic         tx_xtd, tx_remote;
		logic [3:0]   tx_dlc;
		logic [63:0]  tx_data;
		logic         rx_scan, rx_xtd, rx_rtr;
		logic [4:0]   rx_idx;
		logic [28:0]  rx_id;
		logic [3:0]   rx_dlc;
		logic [63:0]  rx_data;
		logic         awready, wready, arready, aw_got, w_got, bvalid, rvalid;
		logic [11:0]  aw_addr;
		logic [31:0]  wdata, rdata;
		logic [3:0]   wstrb;
		logic [1:0]   bresp, rresp;
	} state_t;

	state_t      st_reg;      // Registered state
	state_t      st_next;     // Next state
	msg_obj_t    o;           // Object being worked on
	msg_obj_t    b;           // Interface buffer being worked on
	logic [7:0]  cm;          // Command mask of served set
	logic [32:0] rd;          // Error flag and read word
	logic [31:0] wv;          // Merged write word
	logic [1:0]  sel;         // Interface decode
	logic [5:0]  fp;          // First pending object
	int          s;           // Served interface set
	logic        xfer;        // RAM transfer this cycle
	logic        tx_start;    // Transmit load this cycle
	logic        store_data;  // Data frame stored this cycle
	logic [4:0]  store_idx;   // Object that took it

	// Interface set decode: {hit, set}
	function automatic logic [1:0] if_sel(input logic [11:0] a);
		if_sel = '0;
		if (a[11:7] == 5'h00 && a[4:0] <= DB_OFS && a[1:0] == 2'h0 &&
		    (a[6:5] == IF1_SEL || a[6:5] == IF2_SEL)) begin
			if_sel = {1'b1, a[6]};
		end
	endfunction

	// Lowest numbered valid object with a request: {found, index}
	function automatic logic [5:0] first_pending(input msg_obj_t [NUM_OBJ-1:0] ob);
		first_pending = '0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (ob[i].valid && ob[i].transmit_request) begin
				first_pending = {1'b1, 5'(i)}; // R23
			end
		end
	endfunction

	// Acceptance filter for one object
	function automatic logic obj_match(input msg_obj_t ob, input logic [28:0] id,
	                                   input logic xtd, input logic rtr);
		logic [28:0] care;
		logic        xc;
		logic        dc;
		care = ob.use_acceptance_mask ? ob.mask : '1; // R15
		xc   = ob.use_acceptance_mask ? ob.mask_extended_flag : 1'b1;
		dc   = ob.use_acceptance_mask ? ob.mask_direction_flag : 1'b1;
		if (!xtd) begin
			care[17:0] = '0; // R13
		end
		obj_match = ob.valid && (((ob.id ^ id) & care) == '0) &&
		            (!xc || ob.xtd == xtd) && (!dc || ob.dir == rtr);
	endfunction

	// Copy the field groups the command mask selects
	function automatic msg_obj_t copy_sel(input msg_obj_t d, input msg_obj_t src,
	                                      input logic [7:0] m);
		copy_sel = d;
		if (m[CM_MASK]) begin
			copy_sel.mask = src.mask;
			copy_sel.mask_extended_flag = src.mask_extended_flag;
			copy_sel.mask_direction_flag = src.mask_direction_flag;
		end
		if (m[CM_ARB]) begin
			copy_sel.valid = src.valid;
			copy_sel.xtd   = src.xtd;
			copy_sel.dir   = src.dir;
			copy_sel.id    = src.id;
		end
		if (m[CM_CTRL]) begin
			copy_sel.use_acceptance_mask  = src.use_acceptance_mask;
			copy_sel.end_of_block    = src.end_of_block;
			copy_sel.new_data_flag = src.new_data_flag;
			copy_sel.message_lost_flag = src.message_lost_flag;
			copy_sel.rx_int_enable   = src.rx_int_enable;
			copy_sel.tx_int_enable   = src.tx_int_enable;
			copy_sel.int_pending_flag = src.int_pending_flag;
			copy_sel.remote_reply_enable  = src.remote_reply_enable;
			copy_sel.transmit_request = src.transmit_request;
			copy_sel.dlc    = src.dlc;
		end
		if (m[CM_DATA_A]) begin
			copy_sel.data[31:0] = src.data[31:0];
		end
		if (m[CM_DATA_B]) begin
			copy_sel.data[63:32] = src.data[63:32];
		end
	endfunction

	// Register read decode: {error, word}
	function automatic logic [32:0] read_reg(input state_t q, input logic [11:0] a);
		logic [1:0] hs;
		msg_obj_t   bf;
		hs       = if_sel(a);
		bf       = q.ifs[hs[0]].buffer;
		read_reg = '0;
		if (a == CTL_OFS) begin
			read_reg[CTL_INIT]  = q.init;
			read_reg[CTL_BUSON] = q.bus_active;
		end else if (a == TXRQ_OFS || a == NWDA_OFS) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				read_reg[i] = (a == TXRQ_OFS) ? q.objs[i].transmit_request : q.objs[i].new_data_flag;
			end
		end else if (hs[1]) begin
			case (a[4:0])
				CMSK_OFS: read_reg[7:0] = q.ifs[hs[0]].cmask;
				CRQ_OFS: begin
					read_reg[CRQ_BUSY] = q.ifs[hs[0]].busy;
					read_reg[5:0]      = 6'(q.ifs[hs[0]].idx) + 6'h01;
				end
				MSK_OFS:  read_reg[31:0] = {bf.mask_extended_flag, bf.mask_direction_flag, 1'b0, bf.mask};
				ARB_OFS:  read_reg[31:0] = {bf.valid, bf.xtd, bf.dir, bf.id};
				MCTL_OFS: read_reg[15:0] = {bf.new_data_flag, bf.message_lost_flag, bf.int_pending_flag, bf.use_acceptance_mask,
				                            bf.tx_int_enable, bf.rx_int_enable, bf.remote_reply_enable, bf.transmit_request,
				                            bf.end_of_block, 3'h0, bf.dlc};
				DA_OFS:   read_reg[31:0] = bf.data[31:0];
				DB_OFS:   read_reg[31:0] = bf.data[63:32];
				default:  read_reg[32] = 1'b1;
			endcase
		end else begin
			read_reg[32] = 1'b1; // Unmapped
		end
	endfunction

	// Byte lane merge
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
	                                       input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			wmerge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// Next-state logic; one transfer, load or scan step per cycle keeps objects consistent
	always_comb begin
		st_next    = st_reg;
		o          = '0;
		b          = '0;
		cm         = '0;
		rd         = '0;
		wv         = '0;
		sel        = '0;
		fp         = '0;
		s          = 0;
		xfer       = 1'b0;
		tx_start   = 1'b0;
		store_data = 1'b0;
		store_idx  = '0;
		st_next.tx_load = 1'b0;
		// Address and data captured in either order
		if (awvalid && st_reg.awready) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = wdata;
			st_next.wstrb = wstrb;
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end
		// Register write once both halves are held
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			rd  = read_reg(st_reg, st_reg.aw_addr);
			wv  = wmerge(rd[31:0], st_reg.wdata, st_reg.wstrb);
			sel = if_sel(st_reg.aw_addr);
			s   = int'(sel[0]);
			st_next.bresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
			if (st_reg.aw_addr == CTL_OFS) begin
				st_next.init = wv[CTL_INIT]; // R1
			end else if (sel[1]) begin
				b = st_reg.ifs[s].buffer;
				case (st_reg.aw_addr[4:0])
					CMSK_OFS: st_next.ifs[s].cmask = wv[7:0];
					CRQ_OFS: begin
						// Number 1..32 queues a transfer; ignored while busy
						if (!st_reg.ifs[s].busy && wv[5:0] != 6'h00 && wv[5:0] <= 6'h20) begin
							st_next.ifs[s].busy = 1'b1; // R7
							st_next.ifs[s].idx  = wv[4:0] - 5'h01;
						end
					end
					MSK_OFS: begin
						b.mask = wv[28:0];
						b.mask_extended_flag = wv[MSK_MASK_EXTENDED_FLAG];
						b.mask_direction_flag = wv[MSK_MASK_DIRECTION_FLAG];
					end
					ARB_OFS: begin
						b.id    = wv[28:0];
						b.xtd   = wv[ARB_XTD];
						b.dir   = wv[ARB_DIR];
						b.valid = wv[ARB_VALID];
					end
					MCTL_OFS: begin
						b.new_data_flag = wv[MC_NEW_DATA_FLAG];
						b.message_lost_flag = wv[MC_MESSAGE_LOST_FLAG];
						b.int_pending_flag = wv[MC_INT_PENDING_FLAG];
						b.use_acceptance_mask  = wv[MC_USE_ACCEPTANCE_MASK];
						b.tx_int_enable   = wv[MC_TX_INT_ENABLE];
						b.rx_int_enable   = wv[MC_RX_INT_ENABLE];
						b.remote_reply_enable  = wv[MC_REMOTE_REPLY_ENABLE];
						b.transmit_request = wv[MC_TRANSMIT_REQUEST];
						b.end_of_block    = wv[MC_EOB];
						b.dlc    = wv[3:0];
					end
					DA_OFS:  b.data[31:0]  = wv;
					DB_OFS:  b.data[63:32] = wv;
					default: b = st_reg.ifs[s].buffer;
				endcase
				if (st_reg.aw_addr[4:0] != CMSK_OFS && st_reg.aw_addr[4:0] != CRQ_OFS) begin
					st_next.ifs[s].buffer = b;
				end
			end
		end
		// Read channel
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arvalid && st_reg.arready) begin
			rd = read_reg(st_reg, araddr);
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd[31:0];
			st_next.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end
		// RAM transfer; set one wins a tie, set two waits a cycle
		if (st_reg.ifs[0].busy || st_reg.ifs[1].busy) begin
			xfer = 1'b1;
			s    = st_reg.ifs[0].busy ? 0 : 1; // R26
			o    = st_next.objs[st_reg.ifs[s].idx];
			b    = st_next.ifs[s].buffer;
			cm   = st_next.ifs[s].cmask;
			if (cm[CM_WR]) begin
				o = copy_sel(o, b, cm); // R6
				if (cm[CM_NEW_DATA_FLAG]) begin
					o.transmit_request = 1'b1; // R17
					o.new_data_flag = 1'b1;
				end
				// Fresh data for the frame on the wire keeps its request
				if (st_reg.tx_active && st_reg.ifs[s].idx == st_reg.tx_obj &&
				    (cm[CM_NEW_DATA_FLAG] || cm[CM_DATA_A] || cm[CM_DATA_B] ||
				     (cm[CM_CTRL] && b.new_data_flag))) begin
					st_next.tx_dirty = 1'b1; // R18
				end
			end else begin
				st_next.ifs[s].buffer = copy_sel(b, o, cm);
				if (cm[CM_CLRINT]) begin
					o.int_pending_flag = 1'b0;
				end
				if (cm[CM_NEW_DATA_FLAG]) begin
					o.new_data_flag = 1'b0;
				end
			end
			st_next.objs[st_reg.ifs[s].idx] = o; // R3
			st_next.ifs[s].busy = 1'b0;
		end
		// End of transmission; failure leaves the request for retry
		if (st_reg.tx_active && (tx_done || tx_fail)) begin
			st_next.tx_active = 1'b0; // R11
			if (tx_done) begin
				if (!st_next.tx_dirty) begin
					st_next.objs[st_reg.tx_obj].transmit_request = 1'b0; // R9
				end
				if (st_next.objs[st_reg.tx_obj].tx_int_enable) begin
					st_next.objs[st_reg.tx_obj].int_pending_flag = 1'b1; // R10
				end
			end
		end
		// Load the best pending object into the shift register
		fp = first_pending(st_reg.objs);
		if (!xfer && st_reg.bus_active && !st_reg.tx_active && tx_ready && fp[5]) begin
			tx_start = 1'b1; // R5 R8
			o = st_reg.objs[fp[4:0]];
			st_next.tx_load   = 1'b1;
			st_next.tx_active = 1'b1;
			st_next.tx_dirty  = 1'b0;
			st_next.tx_obj    = fp[4:0];
			st_next.tx_id     = o.id;
			st_next.tx_xtd    = o.xtd;
			st_next.tx_remote = !o.dir; // Receive object asks by remote frame
			st_next.tx_dlc    = o.dlc;
			st_next.tx_data   = o.data; // R14
			st_next.objs[fp[4:0]].new_data_flag = 1'b0; // R8
		end
		// Acceptance scan, one object per free cycle
		if (st_reg.rx_scan && !xfer && !tx_start) begin
			o = st_next.objs[st_reg.rx_idx];
			if (obj_match(o, st_reg.rx_id, st_reg.rx_xtd, st_reg.rx_rtr)) begin
				st_next.rx_scan = 1'b0; // R19
				if (!st_reg.rx_rtr) begin
					store_data = 1'b1;
					store_idx  = st_reg.rx_idx;
					o.message_lost_flag   = o.message_lost_flag | o.new_data_flag; // R20
					o.new_data_flag   = 1'b1;
					o.id       = st_reg.rx_id; // R2
					o.xtd      = st_reg.rx_xtd;
					o.dlc      = st_reg.rx_dlc;
					o.data     = st_reg.rx_data;
					if (o.rx_int_enable) begin
						o.int_pending_flag = 1'b1; // R21
						o.transmit_request = 1'b0;
					end
				end else if (o.dir && o.remote_reply_enable) begin
					o.transmit_request = 1'b1; // R14
				end else if (o.dir && o.use_acceptance_mask) begin
					o.transmit_request = 1'b0; // R22
					o.id     = st_reg.rx_id;
					o.xtd    = st_reg.rx_xtd;
					o.dlc    = st_reg.rx_dlc;
					o.new_data_flag = 1'b1;
				end
				st_next.objs[st_reg.rx_idx] = o;
			end else if (st_reg.rx_idx == 5'h1F) begin
				st_next.rx_scan = 1'b0; // End of RAM, frame dropped
			end else begin
				st_next.rx_idx = st_reg.rx_idx + 5'h01;
			end
		end
		// A new frame restarts the scan at object one
		if (rx_valid && st_reg.bus_active) begin
			st_next.rx_scan = 1'b1;
			st_next.rx_idx  = '0;
			st_next.rx_id   = rx_xtd ? rx_id : {rx_id[28:18], 18'h00000}; // R13
			st_next.rx_xtd  = rx_xtd;
			st_next.rx_rtr  = rx_rtr;
			st_next.rx_dlc  = rx_dlc;
			st_next.rx_data = rx_data;
		end
		// Init stops traffic; leaving it waits for bus idle
		if (st_next.init) begin
			st_next.bus_active = 1'b0; // R1
			st_next.idle_cnt   = '0;
			st_next.tx_active  = 1'b0;
			st_next.rx_scan    = 1'b0;
		end else if (!st_reg.bus_active && bit_strobe) begin
			if (bus_bit) begin
				st_next.idle_cnt = st_reg.idle_cnt + 4'h1;
				if (st_reg.idle_cnt == IDLE_BITS - 4'h1) begin
					st_next.bus_active = 1'b1; // R25
				end
			end else begin
				st_next.idle_cnt = '0; // Dominant bit restarts the count
			end
		end
		// Ready flags as flops so the outputs never glitch
		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready  = !st_next.w_got && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
	end

	// State register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg      <= '0;
			st_reg.init <= CTL_INIT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign awready    = st_reg.awready;
	assign wready     = st_reg.wready;
	assign bvalid     = st_reg.bvalid;
	assign bresp      = st_reg.bresp;
	assign arready    = st_reg.arready;
	assign rvalid     = st_reg.rvalid;
	assign rdata      = st_reg.rdata;
	assign rresp      = st_reg.rresp;
	assign tx_load    = st_reg.tx_load;
	assign tx_id      = st_reg.tx_id;
	assign tx_xtd     = st_reg.tx_xtd;
	assign tx_remote  = st_reg.tx_remote;
	assign tx_dlc     = st_reg.tx_dlc;
	assign tx_data    = st_reg.tx_data;
	assign bus_active = st_reg.bus_active;

	// Checks
	a_init_stops_bus: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		st_reg.init |=> !st_reg.bus_active) else $error("bus active during init");
	a_idle_bits_seen: assert property (@(posedge aclk) disable iff (!aresetn) // R25
		$rose(st_reg.bus_active) |-> $past(st_reg.idle_cnt) == 4'hA)
		else $error("bus joined before eleven idle bits");
	a_tx_ram_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		st_reg.tx_load |-> $past(!st_reg.ifs[0].busy && !st_reg.ifs[1].busy))
		else $error("tx loaded during ram transfer");
	a_tx_new_data_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		st_reg.tx_load |-> !st_reg.objs[st_reg.tx_obj].new_data_flag)
		else $error("new data not cleared on load");
	a_tx_lowest_first: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		st_reg.tx_load |-> $past(first_pending(st_reg.objs)) == {1'b1, st_reg.tx_obj})
		else $error("tx object not highest priority");
	a_iface_fixed_order: assert property (@(posedge aclk) disable iff (!aresetn) // R26
		st_reg.ifs[0].busy && st_reg.ifs[1].busy |=> !st_reg.ifs[0].busy && st_reg.ifs[1].busy)
		else $error("interface transfers out of order");
	a_rx_new_data_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		store_data |-> ##1 st_reg.objs[$past(store_idx)].new_data_flag)
		else $error("new data not set on store");
	a_rx_lost_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		store_data && st_reg.objs[store_idx].new_data_flag |=> st_reg.objs[$past(store_idx)].message_lost_flag)
		else $error("message lost not flagged");
	a_tx_done_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		st_reg.tx_active && tx_done && !st_reg.tx_dirty && !st_reg.rx_scan &&
		!st_reg.ifs[0].busy && !st_reg.ifs[1].busy |=> !st_reg.objs[$past(st_reg.tx_obj)].transmit_request)
		else $error("request not cleared after success");
endmodule // can_message_object_handler
`default_nettype wire

// File: bench/can_core_model.sv
// Protocol core stand-in: transmit shift register handshake and bus bit sampling.
// Assumes one clock shared with the handler and an idle bus with no other sender.
`timescale 1ns/10ps
`default_nettype none
module can_core_model #(
	parameter int TX_CYCLES = 20
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Shift register handshake
	input  wire logic tx_load,
	output logic      tx_ready,
	output logic      tx_done,
	output logic      tx_fail,
	// Sampled bus bits
	output logic      bit_strobe,
	output logic      bus_bit
);
	int         busy_cnt; // Cycles left in the frame
	logic [1:0] bit_div;  // Four clocks per bus bit
	logic       failed;   // First frame already lost
	// One frame at a time; a success or failure pulse ends it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt <= 0;
			tx_done <= 1'b0;
			tx_fail <= 1'b0;
			failed <= 1'b0;
			bit_div <= 2'h0;
		end else begin
			bit_div <= bit_div + 2'h1;
			// First frame loses arbitration so the retry path is exercised
			tx_done <= (busy_cnt == 1) && failed;
			tx_fail <= (busy_cnt == 1) && !failed;
			if (busy_cnt == 1)
				failed <= 1'b1;
			if (tx_load)
				busy_cnt <= TX_CYCLES;
			else if (busy_cnt != 0)
				busy_cnt <= busy_cnt - 1;
		end
	end
	assign tx_ready = (busy_cnt == 0);
	assign bit_strobe = (bit_div == 2'h3);
	// No other node sends, so every sampled bit is recessive
	assign bus_bit = 1'b1;
endmodule // can_core_model
`default_nettype wire

// File: bench/tb.sv
// Testbench for the message handler: AXI4-Lite tasks, tx order, rx storage.
// Assumes the core model above and a 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, rx_valid = 0, rx_rtr = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rd;
	logic [1:0]  rsp;
	logic [28:0] rx_id = {11'h2A5, 18'h15555}; // Low bits must be ignored
	logic [63:0] rx_data = 64'h8877665544332211;
	wire logic   awready, wready, bvalid, arready, rvalid, tx_ready, tx_done, tx_fail;
	wire logic   tx_load, bit_strobe, bus_bit, bus_active;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [28:0] tx_id;
	wire logic [63:0] tx_data;
	logic [28:0] ids[$]; // Identifiers in load order
	int          fail_count = 0, checked = 0, cycles = 0;
	can_message_object_handler dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .bit_strobe, .bus_bit, .rx_valid, .rx_id,
		.rx_xtd(1'b0), .rx_rtr, .rx_dlc(4'h8), .rx_data, .tx_ready, .tx_done, .tx_fail,
		.tx_load, .tx_id, .tx_xtd(), .tx_remote(), .tx_dlc(), .tx_data, .bus_active);
	can_core_model core_u (.aclk, .aresetn, .tx_load, .tx_ready, .tx_done, .tx_fail,
		.bit_strobe, .bus_bit);
	always #2 aclk = ~aclk;
	// Record every frame loaded into the shift register
	always @(posedge aclk) begin
		if (aresetn && tx_load === 1'b1)
			ids.push_back(tx_id);
	end
	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdt(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rdt(a);
		chk(rd, e);
	endtask
	// Command mask, object number, then wait until the set is free
	task automatic xfer(input logic [11:0] b, input logic [7:0] cm, input logic [5:0] n);
		wr(b, {24'h0, cm});
		wr(b + 12'h4, {26'h0, n});
		do
			rdt(b + 12'h4);
		while (rd[15] !== 1'b0);
	endtask
	task automatic setup(input logic [11:0] b, input logic [5:0] n, input logic [7:0] cm,
		input logic [31:0] arb, input logic [31:0] mc);
		wr(b + 12'h8, 32'h0);
		wr(b + 12'hC, arb);
		wr(b + 12'h10, mc);
		wr(b + 12'h14, 32'h03020100);
		wr(b + 12'h18, 32'h07060504); // Both data words whole before transfer
		xfer(b, cm, n);
	endtask
	task automatic rx_frame();
		rx_valid <= 1'b1;
		@(posedge aclk);
		rx_valid <= 1'b0;
		repeat (40) @(posedge aclk);
	endtask
	task conclude();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(12'h000, 32'h1);
		rdt(12'h100);
		chk({30'h0, rsp}, 32'h2);
		wr(12'h100, 32'h1);
		chk({30'h0, rsp}, 32'h2);
		// Object 2 holds the lower identifier yet must go second
		setup(12'h020, 6'd1, 8'hF7, {3'b101, 11'h123, 18'h0}, 32'h8B88);
		setup(12'h040, 6'd2, 8'hF7, {3'b101, 11'h005, 18'h0}, 32'h8188);
		setup(12'h040, 6'd3, 8'hF3, {3'b100, 11'h2A5, 18'h0}, 32'h0480);
		rc(12'h004, 32'h3);
		rc(12'h008, 32'h3);
		wr(12'h000, 32'h0);
		chk({30'h0, rsp}, 32'h0);
		for (int i = 0; i < 200 && bus_active !== 1'b1; i++)
			@(posedge aclk);
		chk({31'h0, bus_active}, 32'h1);
		rc(12'h000, 32'h2);
		while (ids.size() < 3)
			@(posedge aclk);
		repeat (40) @(posedge aclk);
		chk({3'h0, ids[0]}, {3'h0, 11'h123, 18'h0});
		chk({3'h0, ids[1]}, {3'h0, 11'h123, 18'h0});
		chk({3'h0, ids[2]}, {3'h0, 11'h005, 18'h0});
		rc(12'h004, 32'h0);
		rc(12'h008, 32'h0);
		xfer(12'h040, 8'h10, 6'd1);
		rc(12'h050, 32'h2A88);
		// Remote frames: object 1 answers by itself, object 2 ignores
		rx_rtr <= 1'b1;
		rx_id[28:18] <= 11'h123;
		rx_frame();
		rx_id[28:18] <= 11'h005;
		rx_frame();
		chk({3'h0, ids[3]}, {3'h0, 11'h123, 18'h0});
		chk(tx_data[63:32], 32'h07060504);
		chk(ids.size(), 32'h4);
		rx_rtr <= 1'b0;
		rx_id[28:18] <= 11'h2A5;
		// Received data frame lands in object 3
		rx_frame();
		xfer(12'h040, 8'h33, 6'd3);
		rc(12'h050, 32'hA488);
		rc(12'h054, 32'h44332211);
		rc(12'h04C, {3'b100, 11'h2A5, 18'h0});
		rx_frame();
		xfer(12'h040, 8'h33, 6'd3);
		rc(12'h050, 32'hE488);
		conclude();
	end
endmodule // tb
`default_nettype wire
